// ===== ddr3_odt_params.svh
// constants for the on-die termination latency control block
`ifndef DDR3_ODT_PARAMS_SVH
`define DDR3_ODT_PARAMS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ODT_ADR_MR0 8'h00
`define ODT_ADR_MR1 8'h04
`define ODT_ADR_MR2 8'h08
`define ODT_ADR_LAT 8'h0c
`define ODT_ADR_STAT 8'h10

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ODT_MR0_PD_DLL_BIT 12
`define ODT_MR1_NOM_B0 2
`define ODT_MR1_NOM_B1 6
`define ODT_MR1_NOM_B2 9
`define ODT_MR2_WR_B0 9
`define ODT_MR2_WR_B1 10
`define ODT_LAT_CWL_LSB 0
`define ODT_LAT_AL_LSB 8

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ODT_RST_MR 16'h0000
`define ODT_RST_CWL 5'h05
`define ODT_RST_AL 5'h00

// ----------------------------------------------------------------
// timing counts in link clock cycles, and the delay line tap width
// ----------------------------------------------------------------
`define ODT_LAT_SUB 2
`define ODT_ANPD_SUB 1
`define ODT_CWN4_ADD 4
`define ODT_CWN8_ADD 6
`define ODT_TAP_W 5

`endif

// ===== ddr3_odt_pkg.sv
// types shared by the on-die termination latency control block
package ddr3_odt_pkg;

   // pins from the memory controller, all asynchronous to clk_i
   typedef struct packed {
      logic ck;
      logic odt;
      logic cke;
      logic wr;
      logic bc4;
   } link_pins_t;

   // classic wishbone request
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [7:0] adr;
      logic [31:0] dat;
   } wb_req_t;

   // classic wishbone answer
   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } wb_rsp_t;

   // termination state towards the io cells
   typedef struct packed {
      logic on;
      logic wr_sel;
      logic [2:0] code;
      logic async;
      logic trans;
   } rtt_out_t;

endpackage

// ===== odt_delay_line.sv
// odt shift line with a selectable tap, advanced on link clock edges
`timescale 1ns/1ps
module odt_delay_line #(
   parameter int TW = 5
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic shift_i,
   input wire logic din_i,
   input wire logic [TW-1:0] tap_i,
   output logic dout_o
);
   localparam int DEPTH = 2 ** TW;

   typedef struct packed {
      logic [DEPTH-1:0] sr;
   } dl_state_t;

   dl_state_t st_q;
   dl_state_t st_d;

   // shift one stage per detected link edge
   always_comb begin
      st_d = st_q;
      if (shift_i) begin
         st_d.sr = {st_q.sr[DEPTH-2:0], din_i};
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // tap 0 is the sample just registered
   assign dout_o = st_q.sr[tap_i];

   a_shift_in: assert property (@(posedge clk_i) disable iff (rst_i)
      shift_i |=> st_q.sr[0] == $past(din_i))
      else $error("delay line lost its input sample");

endmodule

// ===== ddr3_odt_latency_control.sv
// on-die termination latency control with wishbone mode registers
`timescale 1ns/1ps
`include "ddr3_odt_params.svh"
module ddr3_odt_latency_control #(
   parameter int LAT_W = `ODT_TAP_W
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire ddr3_odt_pkg::wb_req_t wb_i,
   output ddr3_odt_pkg::wb_rsp_t wb_o,
   input wire ddr3_odt_pkg::link_pins_t pins_i,
   input wire logic dll_locked_i,
   input wire logic dq_drive_i,
   output ddr3_odt_pkg::rtt_out_t rtt_o
);
   import ddr3_odt_pkg::*;

   localparam int CW = LAT_W + 1;
   localparam logic [CW-1:0] LAT_MAX = CW'((2 ** LAT_W) - 1);

   typedef struct packed {
      link_pins_t s1;
      link_pins_t s2;
      logic ck3;
      logic [15:0] mr0;
      logic [15:0] mr1;
      logic [15:0] mr2;
      logic [4:0] cwl;
      logic [4:0] al;
      logic ack;
      logic [31:0] rdat;
      logic odt_r;
      logic cke_r;
      logic [CW-1:0] age;
      logic wact;
      logic wbc4;
      logic [CW-1:0] wcnt;
      logic rtt_wr;
      logic [CW-1:0] tcnt;
      rtt_out_t out;
   } ctl_state_t;

   ctl_state_t st_q;
   ctl_state_t st_d;
   logic dl_out;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------

   // write latency minus a constant, floored at zero, capped by the line
   function automatic logic [CW-1:0] wl_minus(input logic [4:0] cwl, input logic [4:0] al,
                                              input int sub);
      logic [6:0] wl;
      logic [6:0] r;
      wl = {2'b00, cwl} + {2'b00, al};
      r = (wl >= 7'(sub)) ? 7'(wl - 7'(sub)) : 7'h00;
      if (r > 7'(LAT_MAX)) begin
         r = 7'(LAT_MAX);
      end
      return r[CW-1:0];
   endfunction

   // byte-lane write merge
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [2:0] nom_code(input logic [15:0] mr1);
      return {mr1[`ODT_MR1_NOM_B2], mr1[`ODT_MR1_NOM_B1], mr1[`ODT_MR1_NOM_B0]};
   endfunction

   function automatic logic [2:0] wr_code(input logic [15:0] mr2);
      return {1'b0, mr2[`ODT_MR2_WR_B1], mr2[`ODT_MR2_WR_B0]};
   endfunction

   // ----------------------------------------------------------------
   // decoded configuration
   // ----------------------------------------------------------------
   logic tick;
   logic term_en;
   logic dyn_en;
   logic async_d;
   logic [CW-1:0] lat;
   logic [CW-1:0] anpd;
   logic [CW-1:0] wnext;
   logic bus_req;
   logic bus_wr;

   // link edge and mode decode
   always_comb begin
      tick = st_q.s2.ck & ~st_q.ck3;
      term_en = (|nom_code(st_q.mr1)) | (|wr_code(st_q.mr2));
      dyn_en = |wr_code(st_q.mr2);
      lat = wl_minus(st_q.cwl, st_q.al, `ODT_LAT_SUB);
      anpd = wl_minus(st_q.cwl, st_q.al, `ODT_ANPD_SUB);
      async_d = dll_locked_i & ~st_q.cke_r & ~st_q.mr0[`ODT_MR0_PD_DLL_BIT];
      wnext = CW'(st_q.wcnt + 1'b1);
      bus_req = wb_i.cyc & wb_i.stb & ~st_q.ack;
      bus_wr = bus_req & wb_i.we;
   end

   odt_delay_line #(.TW(LAT_W)) odt_delay_line_i (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .shift_i(tick),
      .din_i(st_q.s2.odt),
      .tap_i(lat[LAT_W-1:0]),
      .dout_o(dl_out)
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic src;
      logic [31:0] w;
      src = 1'b0;
      w = 32'h0000_0000;
      st_d = st_q;
      // pin synchronisers, first stage only feeds the second
      st_d.s1 = pins_i;
      st_d.s2 = st_q.s1;
      st_d.ck3 = st_q.s2.ck;

      // register writes
      if (bus_wr) begin
         case (wb_i.adr)
            `ODT_ADR_MR0: begin
               w = merge({16'h0000, st_q.mr0}, wb_i.dat, wb_i.sel);
               st_d.mr0 = w[15:0];
            end
            `ODT_ADR_MR1: begin
               w = merge({16'h0000, st_q.mr1}, wb_i.dat, wb_i.sel);
               st_d.mr1 = w[15:0];
            end
            `ODT_ADR_MR2: begin
               w = merge({16'h0000, st_q.mr2}, wb_i.dat, wb_i.sel);
               st_d.mr2 = w[15:0];
            end
            `ODT_ADR_LAT: begin
               w = merge({19'h0, st_q.al, 3'h0, st_q.cwl}, wb_i.dat, wb_i.sel);
               st_d.cwl = w[`ODT_LAT_CWL_LSB +: 5];
               st_d.al = w[`ODT_LAT_AL_LSB +: 5];
            end
            default: begin
               w = 32'h0000_0000;
            end
         endcase
      end

      // register reads, unmapped reads as zero
      st_d.ack = bus_req;
      if (bus_req) begin
         case (wb_i.adr)
            `ODT_ADR_MR0: st_d.rdat = {16'h0000, st_q.mr0};
            `ODT_ADR_MR1: st_d.rdat = {16'h0000, st_q.mr1};
            `ODT_ADR_MR2: st_d.rdat = {16'h0000, st_q.mr2};
            `ODT_ADR_LAT: st_d.rdat = {19'h0, st_q.al, 3'h0, st_q.cwl};
            `ODT_ADR_STAT: st_d.rdat = {26'h0, dyn_en, term_en, st_q.out.trans,
                                        st_q.out.async, st_q.out.wr_sel, st_q.out.on};
            default: st_d.rdat = 32'h0000_0000;
         endcase
      end

      // pins registered on the link rising edge
      if (tick) begin
         st_d.odt_r = st_q.s2.odt;
         st_d.cke_r = st_q.s2.cke;
         if (st_q.s2.odt != st_q.odt_r) begin
            st_d.age = '0;
         end else if (st_q.age != '1) begin
            st_d.age = CW'(st_q.age + 1'b1);
         end
         // transition window after each cke change
         if (st_q.s2.cke != st_q.cke_r) begin
            st_d.tcnt = anpd;
         end else if (st_q.tcnt != '0) begin
            st_d.tcnt = CW'(st_q.tcnt - 1'b1);
         end
         // write strength window
         if (st_q.s2.wr) begin
            st_d.wact = 1'b1;
            st_d.wbc4 = st_q.s2.bc4;
            st_d.wcnt = '0;
            if (lat == '0) begin
               st_d.rtt_wr = 1'b1;
            end
         end else if (st_q.wact) begin
            st_d.wcnt = wnext;
            if (wnext == lat) begin
               st_d.rtt_wr = 1'b1;
            end
            if (wnext == CW'(lat + (st_q.wbc4 ? `ODT_CWN4_ADD : `ODT_CWN8_ADD))) begin
               st_d.rtt_wr = 1'b0;
               st_d.wact = 1'b0;
            end
         end
      end
      if (!dyn_en) begin
         st_d.rtt_wr = 1'b0;
      end

      // termination source by timing mode
      if (async_d) begin
         src = st_q.odt_r;
      end else if (dll_locked_i) begin
         src = dl_out;
      end
      st_d.out.on = term_en & ~dq_drive_i & src;
      st_d.out.wr_sel = st_d.rtt_wr;
      st_d.out.code = st_d.rtt_wr ? wr_code(st_d.mr2) : nom_code(st_d.mr1);
      st_d.out.async = async_d;
      st_d.out.trans = st_d.tcnt != '0;
   end

   // state register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= '0;
         st_q.mr0 <= `ODT_RST_MR;
         st_q.mr1 <= `ODT_RST_MR;
         st_q.mr2 <= `ODT_RST_MR;
         st_q.cwl <= `ODT_RST_CWL;
         st_q.al <= `ODT_RST_AL;
         st_q.cke_r <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   assign wb_o = '{ack: st_q.ack, dat: st_q.rdat};
   assign rtt_o = st_q.out;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_disabled_off: assert property (
      !term_en |=> !st_q.out.on)
      else $error("termination on while all strength bits are zero");

   a_drive_blocks: assert property (
      dq_drive_i |=> !st_q.out.on)
      else $error("termination on while driving data");

   a_sync_mode: assert property (
      (dll_locked_i && st_q.cke_r) |=> !st_q.out.async)
      else $error("asynchronous timing with dll on and cke high");

   a_async_select: assert property (
      (dll_locked_i && !st_q.cke_r && !st_q.mr0[`ODT_MR0_PD_DLL_BIT]) |=> st_q.out.async)
      else $error("frozen dll power-down did not select asynchronous timing");

   a_async_direct: assert property (
      (async_d && term_en && !dq_drive_i) |=> st_q.out.on == $past(st_q.odt_r))
      else $error("asynchronous termination not following sampled odt");

   a_odt_latency: assert property (
      (dll_locked_i && !async_d && term_en && !dq_drive_i && !bus_wr && st_q.age >= lat)
      |=> st_q.out.on == $past(st_q.odt_r))
      else $error("synchronous termination not at odt latency");

   a_nom_no_write: assert property (
      !st_q.wact |-> !st_q.out.wr_sel)
      else $error("write strength without a write in progress");

   a_wr_switch: assert property (
      (tick && dyn_en && st_q.wact && !st_q.s2.wr && wnext == lat && !bus_wr)
      |=> st_q.out.wr_sel ##1 st_q.out.code == wr_code(st_q.mr2))
      else $error("write strength not selected at write latency minus two");

   a_wr_return: assert property (
      (tick && st_q.wact && !st_q.s2.wr && st_q.wbc4
       && wnext == CW'(lat + `ODT_CWN4_ADD))
      |=> !st_q.out.wr_sel && !st_q.wact)
      else $error("nominal strength not restored after chopped burst");

   a_dyn_disabled: assert property (
      !dyn_en |=> !st_q.out.wr_sel)
      else $error("write strength selected with dynamic mode off");

   a_code_select: assert property (
      st_q.out.code == (st_q.rtt_wr ? wr_code(st_q.mr2) : nom_code(st_q.mr1)))
      else $error("strength code does not match selected register bits");

   a_trans_window: assert property (
      (tick && st_q.s2.cke != st_q.cke_r && anpd != '0) |=> st_q.out.trans)
      else $error("transition window not opened on cke change");

endmodule

// ===== ctrl_model.sv
// controller-side pin model: free-running ck, odt, cke and write command pins
`timescale 1ns/1ps
module ctrl_model (
   input wire logic odt_i,
   input wire logic cke_i,
   input wire logic wr_i,
   input wire logic bc4_i,
   output ddr3_odt_pkg::link_pins_t pins_o,
   output int rises_o
);
   import ddr3_odt_pkg::*;
   logic ck = 1'b0;
   logic odt_q = 1'b0;
   logic prev_q = 1'b0;
   logic cke_q = 1'b1;
   logic wr_q = 1'b0;
   logic bc4_q = 1'b0;
   int hold = 0;
   int rises = 0;
   assign pins_o = '{ck, odt_q, cke_q, wr_q, bc4_q};
   assign rises_o = rises;
   // ck keeps running in power-down too
   initial begin
      #1.3;
      forever #16 ck = ~ck;
   end
   // pins move mid-cycle so they are stable around each ck rise
   always @(negedge ck) begin
      odt_q <= odt_i | (odt_q & (hold != 0));
      cke_q <= cke_i;
      wr_q <= wr_i;
      bc4_q <= bc4_i;
   end
   // minimum odt high time after assertion or after a write
   always @(posedge ck) begin
      rises <= rises + 1;
      prev_q <= odt_q;
      if (odt_q && wr_q) begin
         hold <= bc4_q ? 3 : 5;
      end else if (odt_q && !prev_q) begin
         hold <= 3;
      end else if (hold > 0) begin
         hold <= hold - 1;
      end
   end
endmodule

// ===== test_ddr3_odt_latency_control.sv
// self-checking bench for the termination latency control block
`timescale 1ns/1ps
`include "ddr3_odt_params.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
   $display("BAD %s exp %h got %h", n, e, g); end end
module test_ddr3_odt_latency_control;
   import ddr3_odt_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   wb_req_t wb_i = '0;
   wb_rsp_t wb_o;
   link_pins_t pins;
   rtt_out_t rtt_o;
   logic dll_locked = 1'b1;
   logic dq_drive = 1'b0;
   logic odt = 1'b0;
   logic cke = 1'b1;
   logic wr = 1'b0;
   logic bc4 = 1'b0;
   logic [31:0] rd;
   int rises;
   int miscompares = 0;
   int checks = 0;
   int cyc = 0;

   ddr3_odt_latency_control ddr3_odt_latency_control_i (.clk_i(clk_i), .rst_i(rst_i),
      .wb_i(wb_i), .wb_o(wb_o), .pins_i(pins), .dll_locked_i(dll_locked),
      .dq_drive_i(dq_drive), .rtt_o(rtt_o));
   ctrl_model ctrl_model_i (.odt_i(odt), .cke_i(cke), .wr_i(wr), .bc4_i(bc4),
      .pins_o(pins), .rises_o(rises));

   // clock
   always #2 clk_i = ~clk_i;

   task finish_test;
      if (miscompares == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // hang guard
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc > 20000) begin
         miscompares++;
         finish_test;
      end
   end

   // one classic wishbone cycle, read data left in rd
   task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wb_i <= '{1'b1, 1'b1, we, 4'hf, a, d};
      @(posedge clk_i);
      // ends on ack; if ack never comes, only the hang guard ends this wait
      while (wb_o.ack !== 1'b1) begin
         @(posedge clk_i);
      end
      rd = wb_o.dat;
      wb_i <= '0;
   endtask

   // wait for n ck rises
   task rise_n(input int n);
      int t;
      t = rises + n;
      while (rises != t) @(posedge clk_i);
   endtask

   // n ck rises, then let the response settle
   task step(input int n);
      rise_n(n);
      repeat (6) @(posedge clk_i);
   endtask

   // new pin values, registered at the next ck rise
   task apply(input logic o, input logic c, input logic w, input logic b);
      rise_n(1);
      odt <= o;
      cke <= c;
      wr <= w;
      bc4 <= b;
   endtask

   task t_reset;
      `CHK("rtt", 7'h00, rtt_o)
      wb(0, `ODT_ADR_LAT, 0);
      `CHK("lat", 32'h00000005, rd)
      wb(1, `ODT_ADR_MR1, 32'hffff0004);
      wb(0, `ODT_ADR_MR1, 0);
      `CHK("mr1", 32'h00000004, rd)
      wb(0, 8'h20, 0);
      `CHK("unmapped", 32'h00000000, rd)
   endtask

   task t_disabled;
      wb(1, `ODT_ADR_MR1, 0);
      wb(1, `ODT_ADR_MR2, 0);
      apply(1, 1, 0, 0);
      step(6);
      `CHK("on off", 1'b0, rtt_o.on)
      apply(0, 1, 0, 0);
      step(4);
   endtask

   task t_sync;
      int l;
      for (int i = 0; i < 2; i++) begin
         l = 3 + 2 * i;
         wb(1, `ODT_ADR_MR1, i ? 32'h0240 : 32'h0004);
         wb(1, `ODT_ADR_LAT, 32'h00000005 | (i << 9));
         apply(1, 1, 0, 0);
         step(l);
         `CHK("on early", 1'b0, rtt_o.on)
         step(1);
         `CHK("on", 1'b1, rtt_o.on)
         `CHK("nom code", i ? 3'b110 : 3'b001, rtt_o.code)
         apply(0, 1, 0, 0);
         step(l);
         `CHK("off early", 1'b1, rtt_o.on)
         step(1);
         `CHK("off", 1'b0, rtt_o.on)
      end
   endtask

   task t_dyn;
      int d;
      wb(1, `ODT_ADR_MR1, 32'h0004);
      wb(1, `ODT_ADR_LAT, 32'h0005);
      for (int i = 0; i < 4; i++) begin
         d = i[0] ? 4 : 6;
         wb(1, `ODT_ADR_MR2, i[1] ? 32'h0400 : 32'h0200);
         apply(1, 1, 1, i[0]);
         apply(1, 1, 0, 0);
         step(2);
         `CHK("wr_sel early", 1'b0, rtt_o.wr_sel)
         step(1);
         `CHK("wr_sel", 1'b1, rtt_o.wr_sel)
         `CHK("wr code", i[1] ? 3'b010 : 3'b001, rtt_o.code)
         step(d - 1);
         `CHK("wr_sel held", 1'b1, rtt_o.wr_sel)
         step(1);
         `CHK("wr_sel back", 1'b0, rtt_o.wr_sel)
         `CHK("code back", 3'b001, rtt_o.code)
         apply(0, 1, 0, 0);
         step(5);
      end
   endtask

   task t_read;
      apply(1, 1, 0, 0);
      step(4);
      `CHK("on", 1'b1, rtt_o.on)
      dq_drive <= 1'b1;
      repeat (3) @(posedge clk_i);
      `CHK("on driving", 1'b0, rtt_o.on)
      dq_drive <= 1'b0;
      repeat (3) @(posedge clk_i);
      `CHK("on released", 1'b1, rtt_o.on)
      wb(1, `ODT_ADR_MR2, 0);
      dll_locked <= 1'b0;
      repeat (3) @(posedge clk_i);
      `CHK("on dll off", 1'b0, rtt_o.on)
      dll_locked <= 1'b1;
      repeat (3) @(posedge clk_i);
      `CHK("on dll on", 1'b1, rtt_o.on)
      apply(0, 1, 0, 0);
      step(5);
      // legal read: odt already low, termination stays off
      dq_drive <= 1'b1;
      repeat (3) @(posedge clk_i);
      `CHK("read odt low", 1'b0, rtt_o.on)
      dq_drive <= 1'b0;
   endtask

   task t_async;
      wb(1, `ODT_ADR_MR0, 0);
      apply(0, 0, 0, 0);
      step(1);
      `CHK("async", 1'b1, rtt_o.async)
      `CHK("trans", 1'b1, rtt_o.trans)
      wb(0, `ODT_ADR_STAT, 0);
      `CHK("status", 32'h0000001c, rd)
      apply(1, 0, 0, 0);
      step(1);
      `CHK("async on", 1'b1, rtt_o.on)
      step(4);
      apply(0, 0, 0, 0);
      step(1);
      `CHK("async off", 1'b0, rtt_o.on)
      `CHK("trans end", 1'b0, rtt_o.trans)
      apply(0, 1, 0, 0);
      step(1);
      `CHK("sync back", 1'b0, rtt_o.async)
      wb(1, `ODT_ADR_MR0, 32'h1000);
      apply(0, 0, 0, 0);
      step(1);
      `CHK("dll kept", 1'b0, rtt_o.async)
      apply(0, 1, 0, 0);
      step(6);
   endtask

   // main sequence
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      rise_n(2);
      t_reset;
      t_disabled;
      t_sync;
      t_dyn;
      t_read;
      t_async;
      finish_test;
   end
endmodule
